// >>> dpx_exec.sv
// Data pointer executor: pointer loads, external moves, code reads, jumps.
// Assumes one instruction offered per opValid pulse while idle.
`timescale 1ns/1ps
module dpx_exec
	import dpx_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic opValid,
	input wire logic [7:0] opCode,
	input wire logic [7:0] opByte1,
	input wire logic [7:0] opByte2,
	input wire logic [15:0] pcNext,
	input wire logic [7:0] accIn,
	input wire logic [7:0] indirectRegisterZero,
	input wire logic [7:0] indirectRegisterOne,
	input wire logic [7:0] indPageByte,
	input wire logic [7:0] xdRdData,
	input wire logic xdAck,
	input wire logic [7:0] cmRdData,
	input wire logic cmAck,
	output logic busy_ff,
	output logic done_ff,
	output logic [1:0] instrLen_ff,
	output logic [1:0] instrCyc_ff,
	output logic accWe_ff,
	output logic [7:0] accOut_ff,
	output logic jumpValid_ff,
	output logic [15:0] jumpAddr_ff,
	output logic [7:0] dataPointerHighByte_ff,
	output logic [7:0] dataPointerLowByte_ff,
	output logic [15:0] xdAddr_ff,
	output logic [7:0] xdWrData_ff,
	output logic xdRd_ff,
	output logic xdWr_ff,
	output logic [15:0] cmAddr_ff,
	output logic cmRd_ff
);
	dpx_sum_if sumBus ();

	dpx_index_adder u_adder
	(
		.sumPort(sumBus.adder)
	);

	dpx_state_type state_ff;
	dpx_state_type nxt_state;
	dpx_shape_type shape;
	logic [15:0] dataPointer;
	logic [7:0] indAddr;
	logic nxt_busy;
	logic nxt_done;
	logic [1:0] nxt_instrLen;
	logic [1:0] nxt_instrCyc;
	logic nxt_accWe;
	logic [7:0] nxt_accOut;
	logic nxt_jumpValid;
	logic [15:0] nxt_jumpAddr;
	logic [7:0] nxt_dpHigh;
	logic [7:0] nxt_dpLow;
	logic [15:0] nxt_xdAddr;
	logic [7:0] nxt_xdWrData;
	logic nxt_xdRd;
	logic nxt_xdWr;
	logic [15:0] nxt_cmAddr;
	logic nxt_cmRd;

	// Pointer as one 16-bit address
	assign dataPointer = {dataPointerHighByte_ff, dataPointerLowByte_ff};

	// Adder operands
	assign sumBus.acc = accIn;
	assign sumBus.dataPointer = dataPointer;
	assign sumBus.pcNext = pcNext;
	assign sumBus.usePc = (opCode == OP_CODE_RD_PC);

	// Length and cycle decode
	assign shape = dpx_op_shape(opCode);

	// Indirect register select by opcode low bit
	assign indAddr = opCode[0] ? indirectRegisterOne : indirectRegisterZero;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_instrLen = instrLen_ff;
		nxt_instrCyc = instrCyc_ff;
		nxt_accWe = 1'b0;
		nxt_accOut = accOut_ff;
		nxt_jumpValid = 1'b0;
		nxt_jumpAddr = jumpAddr_ff;
		nxt_dpHigh = dataPointerHighByte_ff;
		nxt_dpLow = dataPointerLowByte_ff;
		nxt_xdAddr = xdAddr_ff;
		nxt_xdWrData = xdWrData_ff;
		nxt_xdRd = xdRd_ff;
		nxt_xdWr = xdWr_ff;
		nxt_cmAddr = cmAddr_ff;
		nxt_cmRd = cmRd_ff;
		case (state_ff)
			ST_IDLE:
			begin
				if (opValid)
				begin
					nxt_instrLen = shape.len;
					nxt_instrCyc = shape.cyc;
					nxt_done = 1'b1;
					case (opCode)
						OP_LOAD_DP:
						begin
							nxt_dpHigh = opByte1;
							nxt_dpLow = opByte2;
						end
						OP_MOV_DIR_IMM:
						begin
							// One half only; the other keeps its value
							if (opByte1 == DP_HIGH_DIR_ADDR)
							begin
								nxt_dpHigh = opByte2;
							end
							else if (opByte1 == DP_LOW_DIR_ADDR)
							begin
								nxt_dpLow = opByte2;
							end
						end
						OP_MOV_DIR_ACC:
						begin
							if (opByte1 == DP_HIGH_DIR_ADDR)
							begin
								nxt_dpHigh = accIn;
							end
							else if (opByte1 == DP_LOW_DIR_ADDR)
							begin
								nxt_dpLow = accIn;
							end
						end
						OP_XRD_DP:
						begin
							nxt_xdAddr = dataPointer;
							nxt_xdRd = 1'b1;
						end
						OP_XWR_DP:
						begin
							nxt_xdAddr = dataPointer;
							nxt_xdWrData = accIn;
							nxt_xdWr = 1'b1;
						end
						OP_XRD_IND0, OP_XRD_IND1:
						begin
							nxt_xdAddr = {indPageByte, indAddr};
							nxt_xdRd = 1'b1;
						end
						OP_XWR_IND0, OP_XWR_IND1:
						begin
							nxt_xdAddr = {indPageByte, indAddr};
							nxt_xdWrData = accIn;
							nxt_xdWr = 1'b1;
						end
						OP_CODE_RD_DP, OP_CODE_RD_PC:
						begin
							nxt_cmAddr = sumBus.sum;
							nxt_cmRd = 1'b1;
						end
						OP_INDEXED_JUMP:
						begin
							nxt_jumpAddr = sumBus.sum;
							nxt_jumpValid = 1'b1;
						end
						OP_ROTATE_LEFT:
						begin
							nxt_accOut = {accIn[6:0], accIn[7]};
							nxt_accWe = 1'b1;
						end
						default:
						begin
							nxt_accWe = 1'b0;
						end
					endcase
					// Memory forms finish on acknowledge
					if (nxt_xdRd || nxt_xdWr)
					begin
						nxt_state = ST_XDATA;
						nxt_busy = 1'b1;
						nxt_done = 1'b0;
					end
					else if (nxt_cmRd)
					begin
						nxt_state = ST_CODE;
						nxt_busy = 1'b1;
						nxt_done = 1'b0;
					end
				end
			end
			ST_XDATA:
			begin
				if (xdAck)
				begin
					if (xdRd_ff)
					begin
						nxt_accOut = xdRdData;
						nxt_accWe = 1'b1;
					end
					nxt_xdRd = 1'b0;
					nxt_xdWr = 1'b0;
					nxt_busy = 1'b0;
					nxt_done = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			ST_CODE:
			begin
				if (cmAck)
				begin
					nxt_accOut = cmRdData;
					nxt_accWe = 1'b1;
					nxt_cmRd = 1'b0;
					nxt_busy = 1'b0;
					nxt_done = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			default:
			begin
				nxt_state = ST_IDLE;
				nxt_busy = 1'b0;
				nxt_xdRd = 1'b0;
				nxt_xdWr = 1'b0;
				nxt_cmRd = 1'b0;
			end
		endcase
	end

	// Pointer halves change only on load forms above
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			dataPointerHighByte_ff <= BYTE_ZERO;
			dataPointerLowByte_ff <= BYTE_ZERO;
		end
		else
		begin
			dataPointerHighByte_ff <= nxt_dpHigh;
			dataPointerLowByte_ff <= nxt_dpLow;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_ff <= ST_IDLE;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			instrLen_ff <= LEN_NONE;
			instrCyc_ff <= CYC_NONE;
			accWe_ff <= 1'b0;
			accOut_ff <= BYTE_ZERO;
			jumpValid_ff <= 1'b0;
			jumpAddr_ff <= ADDR_ZERO;
			xdAddr_ff <= ADDR_ZERO;
			xdWrData_ff <= BYTE_ZERO;
			xdRd_ff <= 1'b0;
			xdWr_ff <= 1'b0;
			cmAddr_ff <= ADDR_ZERO;
			cmRd_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			instrLen_ff <= nxt_instrLen;
			instrCyc_ff <= nxt_instrCyc;
			accWe_ff <= nxt_accWe;
			accOut_ff <= nxt_accOut;
			jumpValid_ff <= nxt_jumpValid;
			jumpAddr_ff <= nxt_jumpAddr;
			xdAddr_ff <= nxt_xdAddr;
			xdWrData_ff <= nxt_xdWrData;
			xdRd_ff <= nxt_xdRd;
			xdWr_ff <= nxt_xdWr;
			cmAddr_ff <= nxt_cmAddr;
			cmRd_ff <= nxt_cmRd;
		end
	end
endmodule // dpx_exec

// >>> dpx_pkg.sv
// Constants, opcode encodings and decode helper for the data pointer block.
// Assumes one core clock; all users import the whole package.
package dpx_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	localparam logic [7:0] OP_LOAD_DP = 8'h90;
	localparam logic [7:0] OP_MOV_DIR_IMM = 8'h75;
	localparam logic [7:0] OP_MOV_DIR_ACC = 8'hF5;
	localparam logic [7:0] OP_XRD_DP = 8'hE0;
	localparam logic [7:0] OP_XRD_IND0 = 8'hE2;
	localparam logic [7:0] OP_XRD_IND1 = 8'hE3;
	localparam logic [7:0] OP_XWR_DP = 8'hF0;
	localparam logic [7:0] OP_XWR_IND0 = 8'hF2;
	localparam logic [7:0] OP_XWR_IND1 = 8'hF3;
	localparam logic [7:0] OP_CODE_RD_DP = 8'h93;
	localparam logic [7:0] OP_CODE_RD_PC = 8'h83;
	localparam logic [7:0] OP_INDEXED_JUMP = 8'h73;
	localparam logic [7:0] OP_ROTATE_LEFT = 8'h23;
	localparam logic [7:0] OP_CMP_BRANCH_NE = 8'hB4;
	localparam logic [7:0] OP_LONG_JUMP = 8'h02;
	localparam logic [7:0] OP_SUB_RETURN = 8'h22;
	localparam logic [7:0] SHORT_JUMP_MASK = 8'h1F;
	localparam logic [7:0] SHORT_JUMP_CODE = 8'h01;

	localparam logic [7:0] DP_HIGH_DIR_ADDR = 8'h83;
	localparam logic [7:0] DP_LOW_DIR_ADDR = 8'h82;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] ADDR_ZERO = 16'h0000;
	localparam logic [1:0] LEN_NONE = 2'h0;
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;
	localparam logic [1:0] CYC_NONE = 2'h0;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_XDATA = 2'b01,
		ST_CODE = 2'b10
	} dpx_state_type;

	typedef struct packed
	{
		logic [1:0] len;
		logic [1:0] cyc;
	} dpx_shape_type;

	// Encoded length in bytes and instruction cycles per opcode
	function automatic dpx_shape_type dpx_op_shape(input logic [7:0] op);
		dpx_shape_type s;
		s.len = LEN_NONE;
		s.cyc = CYC_NONE;
		if ((op & SHORT_JUMP_MASK) == SHORT_JUMP_CODE)
		begin
			s.len = LEN_TWO;
			s.cyc = CYC_TWO;
		end
		else
		begin
			case (op)
				OP_LOAD_DP, OP_MOV_DIR_IMM, OP_CMP_BRANCH_NE, OP_LONG_JUMP:
				begin
					s.len = LEN_THREE;
					s.cyc = CYC_TWO;
				end
				OP_MOV_DIR_ACC:
				begin
					s.len = LEN_TWO;
					s.cyc = CYC_ONE;
				end
				OP_ROTATE_LEFT:
				begin
					s.len = LEN_ONE;
					s.cyc = CYC_ONE;
				end
				OP_XRD_DP, OP_XRD_IND0, OP_XRD_IND1, OP_XWR_DP, OP_XWR_IND0,
				OP_XWR_IND1, OP_CODE_RD_DP, OP_CODE_RD_PC, OP_INDEXED_JUMP,
				OP_SUB_RETURN:
				begin
					s.len = LEN_ONE;
					s.cyc = CYC_TWO;
				end
				default:
				begin
					s.len = LEN_NONE;
					s.cyc = CYC_NONE;
				end
			endcase
		end
		return s;
	endfunction
endpackage

// >>> dpx_sum_if.sv
// Interface carrying the indexed address sum between executor and adder.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface dpx_sum_if;
	logic [7:0] acc;
	logic [15:0] dataPointer;
	logic [15:0] pcNext;
	logic usePc;
	logic [15:0] sum;
	modport requester (output acc, output dataPointer, output pcNext,
		output usePc, input sum);
	modport adder (input acc, input dataPointer, input pcNext,
		input usePc, output sum);
endinterface

// >>> dpx_index_adder.sv
// Combinational accumulator plus base adder for indexed addresses.
// Assumes the requester holds inputs stable while it samples the sum.
`timescale 1ns/1ps
module dpx_index_adder
	import dpx_pkg::*;
(
	dpx_sum_if.adder sumPort
);
	logic [15:0] base;
	logic [15:0] accWide;

	always_comb
	begin
		base = sumPort.usePc ? sumPort.pcNext : sumPort.dataPointer;
		accWide = {BYTE_ZERO, sumPort.acc};
		sumPort.sum = 16'(base + accWide);
	end
endmodule // dpx_index_adder

// >>> dpx_exec_properties.sv
// Port assertions for the data pointer executor.
// Assumes a bind onto dpx_exec; single clock domain.
`timescale 1ns/1ps
module dpx_exec_properties
	import dpx_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic opValid,
	input wire logic [7:0] opCode,
	input wire logic [7:0] opByte1,
	input wire logic [7:0] opByte2,
	input wire logic [15:0] pcNext,
	input wire logic [7:0] accIn,
	input wire logic [7:0] indirectRegisterOne,
	input wire logic [7:0] indPageByte,
	input wire logic [7:0] xdRdData,
	input wire logic xdAck,
	input wire logic busy_ff,
	input wire logic done_ff,
	input wire logic accWe_ff,
	input wire logic [7:0] accOut_ff,
	input wire logic jumpValid_ff,
	input wire logic [15:0] jumpAddr_ff,
	input wire logic [7:0] dataPointerHighByte_ff,
	input wire logic [7:0] dataPointerLowByte_ff,
	input wire logic [15:0] xdAddr_ff,
	input wire logic [7:0] xdWrData_ff,
	input wire logic xdRd_ff,
	input wire logic xdWr_ff,
	input wire logic [15:0] cmAddr_ff,
	input wire logic cmRd_ff
);
	logic take;
	logic [15:0] dp;
	assign take = opValid & ~busy_ff & ~xdRd_ff & ~xdWr_ff & ~cmRd_ff;
	assign dp = {dataPointerHighByte_ff, dataPointerLowByte_ff};
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	AST_LOAD: assert property (
		take && opCode == OP_LOAD_DP |=>
		done_ff && dp == {$past(opByte1), $past(opByte2)})
		else $error("pointer load wrong");
	AST_HALF: assert property (
		take && opCode == OP_MOV_DIR_IMM && opByte1 == DP_HIGH_DIR_ADDR |=>
		dataPointerHighByte_ff == $past(opByte2)
		&& $stable(dataPointerLowByte_ff))
		else $error("half write wrong");
	AST_XRD: assert property (
		take && opCode == OP_XRD_DP |=> xdRd_ff && xdAddr_ff == $past(dp))
		else $error("read address wrong");
	AST_XACC: assert property (
		xdRd_ff && xdAck |=>
		accWe_ff && done_ff && !xdRd_ff && accOut_ff == $past(xdRdData))
		else $error("read data wrong");
	AST_XWR: assert property (
		take && opCode == OP_XWR_DP |=>
		xdWr_ff && xdAddr_ff == $past(dp) && xdWrData_ff == $past(accIn))
		else $error("write wrong");
	AST_IND: assert property (
		take && opCode == OP_XRD_IND1 |=> xdRd_ff
		&& xdAddr_ff == {$past(indPageByte), $past(indirectRegisterOne)})
		else $error("indirect address wrong");
	AST_JMP: assert property (
		take && opCode == OP_INDEXED_JUMP |=>
		jumpValid_ff && jumpAddr_ff == $past(dp) + $past(accIn))
		else $error("jump target wrong");
	AST_PCRD: assert property (
		take && opCode == OP_CODE_RD_PC |=>
		cmRd_ff && cmAddr_ff == $past(pcNext) + $past(accIn))
		else $error("code read address wrong");
	AST_ROT: assert property (
		take && opCode == OP_ROTATE_LEFT |=> accWe_ff
		&& accOut_ff == {$past(accIn[6:0]), $past(accIn[7])})
		else $error("rotate wrong");
	AST_HOLD: assert property (
		busy_ff |=> $stable(dp))
		else $error("pointer moved");
endmodule // dpx_exec_properties

// >>> dpx_mem_model.sv
// External data RAM and code memory answering the executor.
// Assumes level requests held until the cycle after the ack.
`timescale 1ns/1ps
module dpx_mem_model
(
	input wire logic mclk,
	input wire logic slow,
	input wire logic [15:0] xdAddr,
	input wire logic [7:0] xdWrData,
	input wire logic xdRd,
	input wire logic xdWr,
	input wire logic [15:0] cmAddr,
	input wire logic cmRd,
	output logic [7:0] xdRdData,
	output logic xdAck,
	output logic [7:0] cmRdData,
	output logic cmAck
);
	logic [7:0] xram [0:65535];
	logic [1:0] xCnt = 2'h0;
	logic [1:0] cCnt = 2'h0;
	logic [1:0] lim;
	initial
	begin
		xdAck = 1'b0;
		cmAck = 1'b0;
		xdRdData = 8'h00;
		cmRdData = 8'h00;
	end
	assign lim = slow ? 2'h2 : 2'h0;
	// Data lines toggle while no answer stands
	always @(posedge mclk)
	begin
		xdAck <= 1'b0;
		cmAck <= 1'b0;
		xdRdData <= ~xdRdData;
		cmRdData <= ~cmRdData;
		if ((xdRd | xdWr) & ~xdAck)
		begin
			xCnt <= xCnt + 2'h1;
			if (xCnt >= lim)
			begin
				xCnt <= 2'h0;
				xdAck <= 1'b1;
				if (xdWr)
					xram[xdAddr] <= xdWrData;
				else
					xdRdData <= xram[xdAddr];
			end
		end
		if (cmRd & ~cmAck)
		begin
			cCnt <= cCnt + 2'h1;
			if (cCnt >= lim)
			begin
				cCnt <= 2'h0;
				cmAck <= 1'b1;
				cmRdData <= cmAddr[7:0] ^ cmAddr[15:8] ^ 8'h5A;
			end
		end
	end
endmodule // dpx_mem_model

// >>> test_data_pointer_indexed_access.sv
// Self-checking bench for the data pointer executor.
// Assumes dpx_exec, dpx_mem_model and the property checker.
`timescale 1ns/1ps
module test_data_pointer_indexed_access
	import dpx_pkg::*;
;
	logic mclk, resetn, opValid, slow, xdAck, cmAck;
	logic busy_ff, done_ff, accWe_ff, jumpValid_ff, xdRd_ff, xdWr_ff, cmRd_ff;
	logic [7:0] opCode, opByte1, opByte2, accIn, xdRdData, cmRdData;
	logic [7:0] indirectRegisterZero, indirectRegisterOne, indPageByte;
	logic [7:0] accOut_ff, dataPointerHighByte_ff, dataPointerLowByte_ff;
	logic [7:0] xdWrData_ff;
	logic [15:0] pcNext, jumpAddr_ff, xdAddr_ff, cmAddr_ff;
	logic [1:0] instrLen_ff, instrCyc_ff;
	int miscompares, nTests;
	dpx_exec dut (.*);
	dpx_mem_model mem (.mclk(mclk), .slow(slow), .xdAddr(xdAddr_ff),
		.xdWrData(xdWrData_ff), .xdRd(xdRd_ff), .xdWr(xdWr_ff),
		.cmAddr(cmAddr_ff), .cmRd(cmRd_ff), .xdRdData(xdRdData),
		.xdAck(xdAck), .cmRdData(cmRdData), .cmAck(cmAck));
	always #25 mclk = ~mclk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	function automatic logic [15:0] dp();
		return {dataPointerHighByte_ff, dataPointerLowByte_ff};
	endfunction
	task automatic setIn(input logic [7:0] r0, r1, pg, input logic [15:0] pc);
		@(posedge mclk);
		indirectRegisterZero <= r0;
		indirectRegisterOne <= r1;
		indPageByte <= pg;
		pcNext <= pc;
	endtask
	task automatic run(input logic [7:0] op, b1, b2, acc);
		int i;
		@(posedge mclk);
		opValid <= 1'b1;
		opCode <= op;
		opByte1 <= b1;
		opByte2 <= b2;
		accIn <= acc;
		@(posedge mclk);
		opValid <= 1'b0;
		#1;
		for (i = 0; i < 20 && done_ff !== 1'b1; i++)
		begin
			@(posedge mclk);
			#1;
		end
		check({15'h0, done_ff}, 16'h0001);
	endtask
	task automatic t_pointer();
		run(OP_LOAD_DP, 8'h12, 8'h34, 8'h00);
		check(dp(), 16'h1234);
		check({12'h0, instrLen_ff, instrCyc_ff}, 16'h000E);
		run(OP_LOAD_DP, 8'hF1, 8'h23, 8'h00);
		run(OP_MOV_DIR_IMM, DP_HIGH_DIR_ADDR, 8'h40, 8'h00);
		check(dp(), 16'h4023);
		run(OP_MOV_DIR_ACC, DP_LOW_DIR_ADDR, 8'h00, 8'h56);
		check(dp(), 16'h4056);
		run(OP_MOV_DIR_IMM, 8'h81, 8'h77, 8'h00);
		check(dp(), 16'h4056);
	endtask
	task automatic t_xdata(input logic s);
		slow = s;
		run(OP_LOAD_DP, 8'h23, 8'h56, 8'h00);
		run(OP_XWR_DP, 8'h00, 8'h00, 8'hA5);
		check(xdAddr_ff, 16'h2356);
		run(OP_XRD_DP, 8'h00, 8'h00, 8'h00);
		check(accOut_ff, 16'h00A5);
		check(dp(), 16'h2356);
		setIn(8'h10, 8'h10, 8'h00, 16'h0000);
		run(OP_XWR_IND0, 8'h00, 8'h00, 8'h3C);
		check(xdAddr_ff, 16'h0010);
		run(OP_XRD_IND1, 8'h00, 8'h00, 8'h00);
		check(accOut_ff, 16'h003C);
		run(OP_LOAD_DP, 8'hFF, 8'hFF, 8'h00);
		run(OP_XWR_DP, 8'h00, 8'h00, 8'hC3);
		setIn(8'hFF, 8'h10, 8'hFF, 16'h0000);
		run(OP_XRD_IND0, 8'h00, 8'h00, 8'h00);
		check(accOut_ff, 16'h00C3);
		run(OP_XWR_IND1, 8'h00, 8'h00, 8'h99);
		check(xdAddr_ff, 16'hFF10);
	endtask
	// Reset in the middle of a slow pointer read
	task automatic t_reset();
		run(OP_LOAD_DP, 8'hAB, 8'hCD, 8'h00);
		@(posedge mclk);
		opValid <= 1'b1;
		opCode <= OP_XRD_DP;
		@(posedge mclk);
		opValid <= 1'b0;
		#1;
		check({15'h0, busy_ff}, 16'h0001);
		@(posedge mclk);
		resetn <= 1'b0;
		#1;
		check({5'h0, busy_ff, done_ff, accWe_ff, jumpValid_ff, xdRd_ff,
			xdWr_ff, cmRd_ff, instrLen_ff, instrCyc_ff}, 16'h0000);
		check(dp(), 16'h0000);
		check(accOut_ff, 16'h0000);
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		#1;
		check({15'h0, busy_ff}, 16'h0000);
	endtask
	task automatic t_code();
		run(OP_LOAD_DP, 8'h12, 8'h34, 8'h00);
		run(OP_CODE_RD_DP, 8'h00, 8'h00, 8'h10);
		check(cmAddr_ff, 16'h1244);
		check(accOut_ff, 8'h12 ^ 8'h44 ^ 8'h5A);
		run(OP_LOAD_DP, 8'hFF, 8'hF0, 8'h00);
		run(OP_CODE_RD_DP, 8'h00, 8'h00, 8'h20);
		check(cmAddr_ff, 16'h0010);
		setIn(8'h00, 8'h00, 8'h00, 16'h2000);
		run(OP_CODE_RD_PC, 8'h00, 8'h00, 8'h05);
		check(cmAddr_ff, 16'h2005);
		check(accOut_ff, 8'h20 ^ 8'h05 ^ 8'h5A);
		check(dp(), 16'hFFF0);
	endtask
	task automatic t_jump();
		run(OP_LOAD_DP, 8'h20, 8'h00, 8'h00);
		run(OP_INDEXED_JUMP, 8'h00, 8'h00, 8'h14);
		check({jumpValid_ff, 15'h0}, 16'h8000);
		check(jumpAddr_ff, 16'h2014);
		check(dp(), 16'h2000);
		run(OP_ROTATE_LEFT, 8'h00, 8'h00, 8'h81);
		check({accWe_ff, 7'h0, accOut_ff}, 16'h8003);
	endtask
	task automatic t_len();
		logic [7:0] ops [4] = '{OP_CMP_BRANCH_NE, 8'h21, OP_LONG_JUMP,
			OP_SUB_RETURN};
		logic [15:0] lens [4] = '{16'h0003, 16'h0002, 16'h0003, 16'h0001};
		for (int i = 0; i < 4; i++)
		begin
			run(ops[i], 8'h00, 8'h00, 8'h00);
			check({14'h0, instrLen_ff}, lens[i]);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		{mclk, resetn, opValid, slow, opCode, opByte1, opByte2, accIn} = '0;
		{indirectRegisterZero, indirectRegisterOne, indPageByte} = '0;
		pcNext = 16'h0000;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		t_pointer();
		t_xdata(1'b0);
		t_xdata(1'b1);
		t_reset();
		t_code();
		t_jump();
		t_len();
		give_verdict();
	end
	initial
	begin
		#200000;
		miscompares++;
		give_verdict();
	end
endmodule // test_data_pointer_indexed_access
bind dpx_exec dpx_exec_properties chk (.*);
